// >>> logic/dual_probe_position_latch.sv
// Summary of operation
// - polarity bits invert external inputs before edges
// - control low byte channel one, high byte two
// - bits 0/8 enable; disabled channel latches nothing
// - bits 1/9: single-shot or continuous mode
// - bit 2: channel one external or index
// - bit 10: channel two external or index
// - bits 4/12 enable rising-edge latching
// - bits 5/13 enable falling-edge latching
// - single-shot accepts only rising edges
// - continuous accepts rising and falling edges
// - change of enable, source or edge bits resets counters and status; a mode-bit change does not
// - live input levels at bits 26, 27
// - signed 32-bit rise/fall positions, reset zero
// - unsigned 32-bit rise/fall counters, reset zero
// - reserved control bits have no effect
// - status echoes enables, flags executed latches
// - continuous values held until next event
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`include "probe_latch_defs.svh"

module dual_probe_position_latch
  import probe_latch_pkg::*;
#(
  parameter int POS_WIDTH = 32,
  parameter int CNT_WIDTH = 32
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // avalon-mm slave
  input  wire logic [`ADDR_WIDTH-1:0] address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  // probe pins, asynchronous to clk
  input  wire logic                   firstExternalLatchInput,
  input  wire logic                   secondExternalLatchInput,
  input  wire logic                   encoderIndexIn,
  // motor feedback position from logic on clk
  input  wire logic [POS_WIDTH-1:0]   motorPosition
);

  // byte-lane merge into a 16-bit object
  function automatic logic [15:0] mergeHalf(input logic [15:0] oldVal,
                                            input logic [31:0] data,
                                            input logic [3:0]  be);
    logic [15:0] res;
    res = oldVal;
    if (be[0]) begin
      res[7:0] = data[7:0];
    end
    if (be[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // one channel's byte of the control word
  function automatic ch_cfg_type chCfg(input logic [15:0] ctrl, input int ch);
    ch_cfg_type res;
    res = ctrl[ch*`CH_STRIDE +: `CH_STRIDE];
    return res;
  endfunction

  // register storage
  logic [15:0]          probeOnePolarity_reg;
  logic [15:0]          probeTwoPolarity_reg;
  logic [15:0]          probeControlWord_reg;
  logic [POS_WIDTH-1:0] risePos_reg   [2];
  logic [POS_WIDTH-1:0] fallPos_reg   [2];
  logic [CNT_WIDTH-1:0] riseCount_reg [2];
  logic [CNT_WIDTH-1:0] fallCount_reg [2];
  logic [1:0]           riseDone_reg;
  logic [1:0]           fallDone_reg;
  logic [15:0]          probeStatusWord;
  logic [31:0]          digitalInputStatus;

  // bus handshake
  bus_state_type        busState_reg;
  bus_state_type        busState_next;
  logic [31:0]          readdata_reg;
  logic [31:0]          readdata_next;
  logic [15:0]          accIndex;
  logic                 busRequest;
  logic                 busCommit;

  // pin synchronisers and edge history
  logic [1:0]           extSync1_reg;
  logic [1:0]           extSync2_reg;
  logic                 zSync1_reg;
  logic                 zSync2_reg;
  logic [1:0]           extLevel;
  logic [1:0]           srcLevel;
  logic [1:0]           srcPrev_reg;

  // configuration tracking and events
  ch_cfg_type           cfgPrev_reg   [2];
  logic [1:0]           cfgChange;
  logic [1:0]           srcChange;
  logic [1:0]           riseEvent;
  logic [1:0]           fallEvent;
  ch_cfg_type           chanCfg       [2];

  assign accIndex   = address[`ADDR_WIDTH-1:`ADDR_IDX_LSB];
  assign busRequest = read | write;
  // the request is held until the edge where waitrequest is seen low
  assign busCommit  = busRequest && (busState_reg == BUS_ACK);

  // one wait state: high in the first cycle of every request
  assign waitrequest = busRequest && (busState_reg == BUS_IDLE);
  assign readdata    = readdata_reg;

  // bus state next value
  always_comb begin
    case (busState_reg)
      BUS_IDLE: begin
        busState_next = busRequest ? BUS_ACK : BUS_IDLE;
      end
      BUS_ACK: begin
        busState_next = BUS_IDLE;
      end
      default: begin
        busState_next = BUS_IDLE;
      end
    endcase
  end

  // bus state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busState_reg <= BUS_IDLE;
    end else begin
      busState_reg <= busState_next;
    end
  end

  // read mux; unmapped indices read as zero
  always_comb begin
    case (accIndex)
      `IDX_PROBE_ONE_POL: readdata_next = {16'h0000, probeOnePolarity_reg};
      `IDX_PROBE_TWO_POL: readdata_next = {16'h0000, probeTwoPolarity_reg};
      `IDX_CTRL_WORD:     readdata_next = {16'h0000, probeControlWord_reg};
      `IDX_STATUS_WORD:   readdata_next = {16'h0000, probeStatusWord};
      `IDX_CH1_RISE_POS:  readdata_next = 32'(risePos_reg[0]);
      `IDX_CH1_FALL_POS:  readdata_next = 32'(fallPos_reg[0]);
      `IDX_CH2_RISE_POS:  readdata_next = 32'(risePos_reg[1]);
      `IDX_CH2_FALL_POS:  readdata_next = 32'(fallPos_reg[1]);
      `IDX_CH1_RISE_CNT:  readdata_next = 32'(riseCount_reg[0]);
      `IDX_CH1_FALL_CNT:  readdata_next = 32'(fallCount_reg[0]);
      `IDX_CH2_RISE_CNT:  readdata_next = 32'(riseCount_reg[1]);
      `IDX_CH2_FALL_CNT:  readdata_next = 32'(fallCount_reg[1]);
      `IDX_DIG_IN_STATUS: readdata_next = digitalInputStatus;
      default:            readdata_next = 32'h0000_0000;
    endcase
  end

  // read data captured in the wait cycle, so it stands when waitrequest drops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readdata_reg <= 32'h0000_0000;
    end else if (read && (busState_reg == BUS_IDLE)) begin
      readdata_reg <= readdata_next;
    end
  end

  // writable objects; read-only and unmapped indices ignore writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      probeOnePolarity_reg <= `POL_RESET;
      probeTwoPolarity_reg <= `POL_RESET;
      probeControlWord_reg <= `CTRL_RESET;
    end else if (busCommit && write) begin
      case (accIndex)
        `IDX_PROBE_ONE_POL: probeOnePolarity_reg <= mergeHalf(probeOnePolarity_reg, writedata, byteenable);
        `IDX_PROBE_TWO_POL: probeTwoPolarity_reg <= mergeHalf(probeTwoPolarity_reg, writedata, byteenable);
        `IDX_CTRL_WORD:     probeControlWord_reg <= mergeHalf(probeControlWord_reg, writedata, byteenable);
        default: begin
        end
      endcase
    end
  end

  // two flops per pin; nothing looks at the first stage but the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      extSync1_reg <= 2'h0;
      extSync2_reg <= 2'h0;
      zSync1_reg   <= 1'b0;
      zSync2_reg   <= 1'b0;
    end else begin
      extSync1_reg <= {secondExternalLatchInput, firstExternalLatchInput};
      extSync2_reg <= extSync1_reg;
      zSync1_reg   <= encoderIndexIn;
      zSync2_reg   <= zSync1_reg;
    end
  end

  assign extLevel[0] = extSync2_reg[0] ^ probeOnePolarity_reg[`POL_FIRST_EXTERNAL_LATCH_INPUT_BIT];
  assign extLevel[1] = extSync2_reg[1] ^ probeTwoPolarity_reg[`POL_SECOND_EXTERNAL_LATCH_INPUT_BIT];

  // per-channel control byte as a net, since a function result cannot be bit-selected
  assign chanCfg[0] = chCfg(probeControlWord_reg, 0);
  assign chanCfg[1] = chCfg(probeControlWord_reg, 1);

  assign srcLevel[0] = chanCfg[0][`CTL_SRC_BIT] ? zSync2_reg : extLevel[0];
  assign srcLevel[1] = chanCfg[1][`CTL_SRC_BIT] ? zSync2_reg : extLevel[1];

  always_comb begin
    digitalInputStatus                = 32'h0000_0000;
    digitalInputStatus[`DIN_FIRST_EXTERNAL_LATCH_INPUT_BIT] = extSync2_reg[0];
    digitalInputStatus[`DIN_SECOND_EXTERNAL_LATCH_INPUT_BIT] = extSync2_reg[1];
  end

  // edge history and config history, one entry per channel
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      srcPrev_reg    <= 2'h0;
      cfgPrev_reg[0] <= 8'h00;
      cfgPrev_reg[1] <= 8'h00;
    end else begin
      srcPrev_reg <= srcLevel;
      for (int i = 0; i < 2; i++) begin
        cfgPrev_reg[i] <= chCfg(probeControlWord_reg, i);
      end
    end
  end

  // event qualification per channel
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cfgChange[i] = ((chCfg(probeControlWord_reg, i) ^ cfgPrev_reg[i]) & `CTL_TRACK_MASK) != 8'h00;
      srcChange[i] = chanCfg[i][`CTL_SRC_BIT] != cfgPrev_reg[i][`CTL_SRC_BIT];
      // continuous: both edges
      // a source switch compares two unrelated signals, so its edge is dropped
      riseEvent[i] = chanCfg[i][`CTL_EN_BIT]
                   & chanCfg[i][`CTL_RISE_BIT]
                   & srcLevel[i] & ~srcPrev_reg[i] & ~srcChange[i]
                   & ~(~chanCfg[i][`CTL_MODE_BIT] & riseDone_reg[i] & ~cfgChange[i]);
      fallEvent[i] = chanCfg[i][`CTL_EN_BIT]
                   & chanCfg[i][`CTL_FALL_BIT]
                   & chanCfg[i][`CTL_MODE_BIT]
                   & ~srcLevel[i] & srcPrev_reg[i] & ~srcChange[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 2; i++) begin
        risePos_reg[i] <= '0;
        fallPos_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (riseEvent[i]) begin
          risePos_reg[i] <= motorPosition;
        end
        if (fallEvent[i]) begin
          fallPos_reg[i] <= motorPosition;
        end
      end
    end
  end

  // config change clears counters; a same-cycle event still counts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 2; i++) begin
        riseCount_reg[i] <= '0;
        fallCount_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (cfgChange[i]) begin
          riseCount_reg[i] <= CNT_WIDTH'(riseEvent[i]);
          fallCount_reg[i] <= CNT_WIDTH'(fallEvent[i]);
        end else begin
          riseCount_reg[i] <= riseCount_reg[i] + CNT_WIDTH'(riseEvent[i]);
          fallCount_reg[i] <= fallCount_reg[i] + CNT_WIDTH'(fallEvent[i]);
        end
      end
    end
  end

  // executed flags cleared on config change, set wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      riseDone_reg <= 2'h0;
      fallDone_reg <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        riseDone_reg[i] <= riseEvent[i] | (riseDone_reg[i] & ~cfgChange[i]);
        fallDone_reg[i] <= fallEvent[i] | (fallDone_reg[i] & ~cfgChange[i]);
      end
    end
  end

  // status echoes enable and executed flags
  always_comb begin
    probeStatusWord = 16'h0000;
    for (int i = 0; i < 2; i++) begin
      probeStatusWord[i*`CH_STRIDE + `STS_EN_BIT]   = chanCfg[i][`CTL_EN_BIT];
      probeStatusWord[i*`CH_STRIDE + `STS_RISE_BIT] = riseDone_reg[i];
      probeStatusWord[i*`CH_STRIDE + `STS_FALL_BIT] = fallDone_reg[i];
    end
  end

endmodule

// >>> include/probe_latch_defs.svh
`ifndef PROBE_LATCH_DEFS_SVH
`define PROBE_LATCH_DEFS_SVH

// object indices; byte address on the bus is four times the index
`define IDX_PROBE_ONE_POL   16'h2007
`define IDX_PROBE_TWO_POL   16'h2107
`define IDX_CTRL_WORD       16'h60b8
`define IDX_STATUS_WORD     16'h60b9
`define IDX_CH1_RISE_POS    16'h60ba
`define IDX_CH1_FALL_POS    16'h60bb
`define IDX_CH2_RISE_POS    16'h60bc
`define IDX_CH2_FALL_POS    16'h60bd
`define IDX_CH1_RISE_CNT    16'h60d5
`define IDX_CH1_FALL_CNT    16'h60d6
`define IDX_CH2_RISE_CNT    16'h60d7
`define IDX_CH2_FALL_CNT    16'h60d8
`define IDX_DIG_IN_STATUS   16'h60fd

// bus geometry
`define ADDR_WIDTH          18
`define ADDR_IDX_LSB        2

// reset values
`define POL_RESET           16'h0001
`define CTRL_RESET          16'h0000

// polarity bits
`define POL_FIRST_EXTERNAL_LATCH_INPUT_BIT        0
`define POL_SECOND_EXTERNAL_LATCH_INPUT_BIT        1

// per-channel field layout inside one byte of the control word
`define CH_STRIDE           8
`define CTL_EN_BIT          0
`define CTL_MODE_BIT        1
`define CTL_SRC_BIT         2
`define CTL_RISE_BIT        4
`define CTL_FALL_BIT        5
`define CTL_TRACK_MASK      8'h35

// status word layout inside one byte
`define STS_EN_BIT          0
`define STS_RISE_BIT        1
`define STS_FALL_BIT        2

// live level positions in the digital input status object
`define DIN_FIRST_EXTERNAL_LATCH_INPUT_BIT        26
`define DIN_SECOND_EXTERNAL_LATCH_INPUT_BIT        27

`endif

// >>> include/probe_latch_pkg.sv
package probe_latch_pkg;

  // bus handshake state, one wait state per access
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_type;

  typedef logic [7:0] ch_cfg_type;

endpackage

// >>> tb/probe_latch_chk.sv
`timescale 1ns/10ps
`include "probe_latch_defs.svh"
module probe_latch_chk (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   arst_n,
  // register bus
  input wire logic [`ADDR_WIDTH-1:0] address,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  // probe pins
  input wire logic                   firstExternalLatchInput,
  input wire logic                   secondExternalLatchInput
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [2:0]  stab;
  logic [15:0] idx;
  assign idx = address[`ADDR_WIDTH-1:2];
  // quiet time of the pins, so a level read is not judged mid-synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stab <= 3'h0;
    end else if ($changed({firstExternalLatchInput, secondExternalLatchInput})) begin
      stab <= 3'h0;
    end else if (stab != 3'h7) begin
      stab <= stab + 3'h1;
    end
  end
  sequence s_wait;
    (read || write) && waitrequest;
  endsequence
  sequence s_done(logic [15:0] i);
    read && !waitrequest && idx == i;
  endsequence
  property p_first;
    (read || write) && !$past(read || write) |-> waitrequest;
  endproperty
  a_first: assert property (p_first) else $error("request start without wait state");
  property p_one;
    s_wait |=> !waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("more than one wait state");
  property p_idle;
    !(read || write) |-> !waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("wait state without request");
  property p_stand;
    !$past(read && waitrequest) |-> $stable(readdata);
  endproperty
  a_stand: assert property (p_stand) else $error("read data moved without a read");
  property p_first_external_latch_input;
    s_done(16'h60fd) ##0 (stab > 3'h3) |-> readdata[26] == firstExternalLatchInput;
  endproperty
  a_first_external_latch_input: assert property (p_first_external_latch_input) else $error("first pin level wrong");
  property p_second_external_latch_input;
    s_done(16'h60fd) ##0 (stab > 3'h3) |-> readdata[27] == secondExternalLatchInput;
  endproperty
  a_second_external_latch_input: assert property (p_second_external_latch_input) else $error("second pin level wrong");
  property p_half;
    read && !waitrequest && idx inside {16'h2007, 16'h2107, 16'h60b8, 16'h60b9} |-> readdata[31:16] == 16'h0;
  endproperty
  a_half: assert property (p_half) else $error("upper half of short object not zero");
  property p_unmapped;
    read && !waitrequest && !(idx inside {16'h2007, 16'h2107, [16'h60b8:16'h60bd], [16'h60d5:16'h60d8],
      16'h60fd}) |-> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

// >>> tb/probe_source.sv
`timescale 1ns/10ps
module probe_source (
  // clock
  input wire logic clk,
  // probe pins and feedback position
  output logic        first_external_latch_input,
  output logic        second_external_latch_input,
  output logic        indexPulse,
  output logic [31:0] position
);
  // pins idle low
  initial begin
    first_external_latch_input = 1'b0;
    second_external_latch_input = 1'b0;
    indexPulse = 1'b0;
    position = 32'h0;
  end
  // one clean transition
  // position holds until the next call, so the capture value is known
  task automatic drive(input int sel, input logic lvl, input logic [31:0] p);
    position <= p;
    case (sel)
      0: first_external_latch_input <= lvl;
      1: second_external_latch_input <= lvl;
      default: indexPulse <= lvl;
    endcase
    repeat (6) @(posedge clk);
  endtask
endmodule

// >>> tb/tb_dual_probe_position_latch.sv
`timescale 1ns/10ps
`include "probe_latch_defs.svh"
module tb_dual_probe_position_latch;
  logic                   clk;
  logic                   arst_n;
  logic [`ADDR_WIDTH-1:0] address;
  logic                   read;
  logic                   write;
  logic [31:0]            writedata;
  logic [3:0]             byteenable;
  logic [31:0]            readdata;
  logic                   waitrequest;
  logic                   first_external_latch_input;
  logic                   second_external_latch_input;
  logic                   indexPulse;
  logic [31:0]            position;
  logic [31:0]            q;
  logic [31:0]            seed;
  logic [31:0]            rc [2];
  logic [31:0]            fc [2];
  logic [31:0]            rp [2];
  logic [31:0]            fp [2];
  int                     nFail;
  int                     cmpCount;
  logic [15:0]            ids [14] = '{16'h2007, 16'h2107, 16'h60b8, 16'h60b9, 16'h60ba, 16'h60bb, 16'h60bc,
                                       16'h60bd, 16'h60d5, 16'h60d6, 16'h60d7, 16'h60d8, 16'h60fd, 16'h1234};
  // 250 MHz
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  dual_probe_position_latch DUT (.clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .firstExternalLatchInput(first_external_latch_input), .secondExternalLatchInput(second_external_latch_input), .encoderIndexIn(indexPulse),
    .motorPosition(position));
  probe_source src (.clk(clk), .first_external_latch_input(first_external_latch_input), .second_external_latch_input(second_external_latch_input), .indexPulse(indexPulse), .position(position));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one access, held until waitrequest is sampled low; one idle edge after
  // only the watchdog ends a hung wait; exactly one wait state is expected
  task automatic bus(input logic w, input logic [15:0] i, input logic [31:0] d);
    logic [31:0] t;
    int          n;
    t = rnd();
    n = 0;
    address <= {i, 2'b00};
    read <= ~w;
    write <= w;
    writedata <= d;
    byteenable <= {t[1:0], 2'b11};
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0);
    q = readdata;
    chk("wait cycles", 32'(n), 32'h2);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] i, input logic [31:0] e);
    bus(1'b0, i, 32'h0);
    chk($sformatf("index %h", i), q, e);
  endtask
  // expected effect of one pin transition on both channels
  function automatic void model(input logic [15:0] c, input int sel, input logic [1:0] inv, input logic lvl,
                                input logic [31:0] p);
    logic [7:0] b;
    logic       up;
    for (int ch = 0; ch < 2; ch++) begin
      b = c[8*ch +: 8];
      up = lvl ^ (inv[ch] & ~b[2]);
      if (b[0] && (b[2] ? sel == 2 : sel == ch)) begin
        if (up && b[4] && (b[1] || rc[ch] == 0)) begin
          rc[ch]++;
          rp[ch] = p;
        end
        if (!up && b[5] && b[1]) begin
          fc[ch]++;
          fp[ch] = p;
        end
      end
    end
  endfunction
  // clear, set polarity while disabled, configure, pulse, read everything back
  task automatic run(input logic [15:0] c, input int sel, input logic [1:0] inv, input int n);
    logic [15:0] st;
    logic [31:0] p;
    bus(1'b1, 16'h60b8, 32'h3535);
    bus(1'b1, 16'h60b8, 32'h0);
    bus(1'b1, 16'h2007, {31'h0, inv[0]});
    bus(1'b1, 16'h2107, {30'h0, inv[1], 1'b0});
    repeat (8) @(posedge clk);
    bus(1'b1, 16'h60b8, {16'h0, c});
    rc = '{default: 32'h0};
    fc = '{default: 32'h0};
    bus(1'b0, 16'h60b8, 32'h0);
    chk("control", q & 32'h3737, {16'h0, c & 16'h3737});
    repeat (n) begin
      p = rnd();
      src.drive(sel, 1'b1, p);
      model(c, sel, inv, 1'b1, p);
      rd(16'h60fd, {4'h0, sel == 1, sel == 0, 26'h0});
      p = rnd();
      src.drive(sel, 1'b0, p);
      model(c, sel, inv, 1'b0, p);
    end
    for (int ch = 0; ch < 2; ch++) begin
      rd(16'h60ba + 16'(2 * ch), rp[ch]);
      rd(16'h60bb + 16'(2 * ch), fp[ch]);
      rd(16'h60d5 + 16'(2 * ch), rc[ch]);
      rd(16'h60d6 + 16'(2 * ch), fc[ch]);
      st[8*ch +: 8] = {5'h0, fc[ch] != 0, rc[ch] != 0, c[8*ch]};
    end
    rd(16'h60b9, {16'h0, st});
  endtask
  task automatic endOfTest();
    $display("TB: %0d mismatches in %0d comparisons", nFail, cmpCount);
    if (nFail == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, several times the expected run
  initial begin
    repeat (20000) @(posedge clk);
    nFail++;
    endOfTest();
  end
  initial begin
    logic [31:0] t;
    seed = 32'h0001446d;
    nFail = 0;
    cmpCount = 0;
    arst_n = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'hf;
    rp = '{default: 32'h0};
    fp = '{default: 32'h0};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    // writes to read-only and unmapped places are dropped
    for (int k = 3; k < 14; k++) bus(1'b1, ids[k], 32'hffffffff);
    for (int k = 0; k < 14; k++) rd(ids[k], k < 2 ? 32'h1 : 32'h0);
    // corner cases first, then random configurations
    run(16'h00fb, 0, 2'b00, 2);
    run(16'h3100, 1, 2'b10, 2);
    run(16'h0535, 2, 2'b00, 1);
    run(16'h3232, 0, 2'b11, 1);
    repeat (36) begin
      t = rnd();
      run(t[15:0], int'(t[17:16] % 3), t[19:18], int'(t[21:20] % 3) + 1);
    end
    endOfTest();
  end
endmodule
bind dual_probe_position_latch probe_latch_chk probeCheck (.clk(clk), .arst_n(arst_n), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .firstExternalLatchInput(firstExternalLatchInput), .secondExternalLatchInput(secondExternalLatchInput));
